// ---- src/stpc_pkg.sv ----
package stpc_pkg;
  localparam logic [11:0] STPC_OFS_EVEN = 12'h258;
  localparam logic [11:0] STPC_OFS_ODD = 12'h25c;
  localparam logic [11:0] STPC_OFS_PAT0 = 12'h210;
  localparam logic [11:0] STPC_OFS_PAT1 = 12'h214;
  localparam logic [11:0] STPC_OFS_PAT2 = 12'h218;
  localparam logic [11:0] STPC_OFS_PAT3 = 12'h21c;
  localparam logic [11:0] STPC_OFS_ERR = 12'h2f0;
  localparam int STPC_DLY0_LSB = 0;
  localparam int STPC_DLY1_LSB = 2;
  localparam int STPC_UEN_LSB = 16;
  localparam int STPC_PEN_LSB = 24;
  localparam logic [31:0] STPC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] STPC_PRBS_POLY = 32'h0060_0001;
  localparam logic [31:0] STPC_PRBS_SEED = 32'h0000_0001;
  localparam logic [3:0] STPC_SYM_0 = 4'h0;
  localparam logic [3:0] STPC_SYM_1 = 4'h1;
  localparam logic [3:0] STPC_SYM_4 = 4'h4;
  localparam logic [3:0] STPC_SYM_8 = 4'h8;
  localparam int STPC_NLANE = 4;
  // cycles from a transmitted symbol to its synchronised echo
  localparam logic [1:0] STPC_ECHO_LAT = 2'h3;
  typedef struct packed {
    logic [1:0] dly;
    logic uen;
    logic pen;
  } stpc_lane_cfg_t;
  typedef struct packed {
    logic [7:0] sym;
    logic valid;
  } stpc_sym_t;
endpackage

// ---- src/stpc_top.sv ----
// Notes on behaviour
// - lane 0 user pattern start delayed 0, 1, 4 or 8 symbol times by code.
// - lane 1 uses same delay encoding from bits 3:2 of even register.
// - lane 4 user pattern start delay uses same encoding, odd register bits 1:0.
// - lane 5 delay from odd register bits 3:2, same encoding.
// - even serdes user enable sends 128-bit pattern registers as loopback master.
// - odd serdes user enable sends the same 128-bit pattern.
// - even serdes prbs enable turns on generator and checker; off when clear.
// - odd serdes prbs enable turns on generator and checker; off when clear.
// - user enable clear means no user pattern is transmitted.
//
// Our own choice: the strobed register port.
module stpc_top
  import stpc_pkg::*;
#(
  parameter logic [31:0] PRBS_POLY = STPC_PRBS_POLY
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [31:0] rdata,
  input wire logic [7:0] rx_sym [STPC_NLANE],
  output stpc_sym_t tx [STPC_NLANE]
);
  logic [31:0] even_r;
  logic [31:0] odd_r;
  logic [31:0] pat_r [4];
  logic [31:0] rdata_r;
  logic [STPC_NLANE-1:0] err_r;
  logic [7:0] rx_s1_r [STPC_NLANE];
  logic [7:0] rx_s2_r [STPC_NLANE];
  logic [127:0] pattern;
  logic [31:0] rd_mux;
  wire hit_even = addr == STPC_OFS_EVEN;
  wire hit_odd = addr == STPC_OFS_ODD;
  wire hit_err = addr == STPC_OFS_ERR;
  wire [3:0] hit_pat = {addr == STPC_OFS_PAT3, addr == STPC_OFS_PAT2,
                        addr == STPC_OFS_PAT1, addr == STPC_OFS_PAT0};
  // error clear is write-one; a new mismatch in the same cycle wins
  wire [STPC_NLANE-1:0] err_clr = (wr && hit_err) ? wdata[STPC_NLANE-1:0] : '0;
  assign pattern = {pat_r[3], pat_r[2], pat_r[1], pat_r[0]};

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_even)
      rd_mux = even_r;
    else if (hit_odd)
      rd_mux = odd_r;
    else if (hit_err)
      rd_mux = {28'h000_0000, err_r};
    else
      for (int i = 0; i < 4; i++)
        if (hit_pat[i])
          rd_mux = pat_r[i];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      even_r <= STPC_CTRL_RST;
      odd_r <= STPC_CTRL_RST;
      rdata_r <= 32'h0000_0000;
      for (int i = 0; i < 4; i++)
        pat_r[i] <= 32'h0000_0000;
    end
    else
    begin
      if (wr && hit_even)
        even_r <= wdata;
      if (wr && hit_odd)
        odd_r <= wdata;
      for (int i = 0; i < 4; i++)
        if (wr && hit_pat[i])
          pat_r[i] <= wdata;
      rdata_r <= rd ? rd_mux : 32'h0000_0000;
    end
  end
  assign rdata = rdata_r;

  // lane 0,1 -> even register serdes 0,1; lane 2,3 -> odd register serdes 4,5
  genvar g;
  generate
    for (g = 0; g < STPC_NLANE; g++)
    begin : g_lane
      localparam int SUB = g % 2;
      stpc_lane_cfg_t cfg;
      logic [3:0] dly_syms;
      logic [3:0] wait_r;
      logic [3:0] idx_r;
      logic started_r;
      logic [31:0] gen_r;
      logic [31:0] chk_r;
      logic uen_q_r;
      logic [1:0] warm_r;
      stpc_sym_t tx_r;
      wire [31:0] src = (g < 2) ? even_r : odd_r;
      assign cfg.dly = src[STPC_DLY0_LSB + 2*SUB +: 2];
      assign cfg.uen = src[STPC_UEN_LSB + SUB];
      assign cfg.pen = src[STPC_PEN_LSB + SUB];
      assign dly_syms = (cfg.dly == 2'b00) ? STPC_SYM_0 :
                        (cfg.dly == 2'b01) ? STPC_SYM_1 :
                        (cfg.dly == 2'b10) ? STPC_SYM_4 : STPC_SYM_8;
      wire [31:0] gen_nxt = gen_r[31] ? ((gen_r << 1) ^ PRBS_POLY) : (gen_r << 1);
      wire [31:0] chk_nxt = chk_r[31] ? ((chk_r << 1) ^ PRBS_POLY) : (chk_r << 1);
      wire uen_go = cfg.uen && !cfg.pen;
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
        begin
          wait_r <= 4'h0;
          idx_r <= 4'h0;
          started_r <= 1'b0;
          uen_q_r <= 1'b0;
          warm_r <= 2'h0;
          gen_r <= STPC_PRBS_SEED;
          chk_r <= STPC_PRBS_SEED;
          rx_s1_r[g] <= 8'h00;
          rx_s2_r[g] <= 8'h00;
          tx_r <= '0;
        end
        else
        begin
          rx_s1_r[g] <= rx_sym[g];
          rx_s2_r[g] <= rx_s1_r[g];
          uen_q_r <= uen_go;
          tx_r <= '0;
          if (uen_go && !uen_q_r)
          begin
            wait_r <= dly_syms;
            started_r <= (dly_syms == STPC_SYM_0);
            idx_r <= 4'h0;
          end
          else if (uen_go && !started_r)
          begin
            if (wait_r <= 4'h1)
              started_r <= 1'b1;
            wait_r <= wait_r - 4'h1;
          end
          else if (uen_go)
          begin
            tx_r.valid <= 1'b1;
            tx_r.sym <= pattern[{idx_r, 3'b000} +: 8];
            idx_r <= idx_r + 4'h1;
          end
          if (!uen_go)
            started_r <= 1'b0;
          if (cfg.pen)
          begin
            gen_r <= gen_nxt;
            // checker holds its seed until the first echo arrives
            if (warm_r == STPC_ECHO_LAT)
              chk_r <= chk_nxt;
            else
              warm_r <= warm_r + 2'h1;
            tx_r.valid <= 1'b1;
            tx_r.sym <= gen_r[7:0];
          end
          else
          begin
            gen_r <= STPC_PRBS_SEED;
            chk_r <= STPC_PRBS_SEED;
            warm_r <= 2'h0;
          end
        end
      end
      assign tx[g] = tx_r;
      // checker compares the delayed partner copy against its own sequence
      wire mism = cfg.pen && (warm_r == STPC_ECHO_LAT) && (rx_s2_r[g] != chk_r[7:0]);
      always_ff @(posedge clk or negedge nrst)
      begin
        if (!nrst)
          err_r[g] <= 1'b0;
        else if (mism)
          err_r[g] <= 1'b1;
        else if (err_clr[g])
          err_r[g] <= 1'b0;
      end
    end
  endgenerate
endmodule

// ---- bench/stpc_top_assertions.sv ----
module stpc_chk
  import stpc_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [11:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [31:0] rdata,
  input wire logic [7:0] rx_sym [STPC_NLANE],
  input stpc_sym_t tx [STPC_NLANE]
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  wire we = wr && addr == STPC_OFS_EVEN;
  wire wo = wr && addr == STPC_OFS_ODD;
  dly_eight_a: assert property (
    we && wdata[17:16] == 2'h1 && !wdata[24] && wdata[1:0] == 2'h3 && !tx[0].valid
    |-> ##3 !tx[0].valid [*8]) else $error("lane 0 started early");
  dly_none_a: assert property (
    we && wdata[17:16] == 2'h2 && !wdata[25] && wdata[3:2] == 2'h0 && !tx[1].valid
    |-> ##[2:6] tx[1].valid) else $error("lane 1 late");
  dly_four_a: assert property (
    wo && wdata[17:16] == 2'h1 && !wdata[24] && wdata[1:0] == 2'h2 && !tx[2].valid
    |-> ##3 !tx[2].valid [*4]) else $error("lane 2 started early");
  dly_one_a: assert property (
    wo && wdata[17:16] == 2'h2 && !wdata[25] && wdata[3:2] == 2'h1 && !tx[3].valid
    |-> ##[3:7] tx[3].valid) else $error("lane 3 late");
  prbs_even_a: assert property (we && wdata[24] |-> ##[1:5] tx[0].valid)
    else $error("no prbs on lane 0");
  prbs_odd_a: assert property (wo && wdata[25] |-> ##[1:5] tx[3].valid)
    else $error("no prbs on lane 3");
  off_even_a: assert property (we && !wdata[16] && !wdata[24] |-> ##3 !tx[0].valid)
    else $error("lane 0 still sending");
  off_odd_a: assert property (wo && !wdata[17] && !wdata[25] |-> ##3 !tx[3].valid)
    else $error("lane 3 still sending");
  cover property (we && wdata[16]);
  cover property ($rose(tx[0].valid));
  cover property (wo && wdata[25]);
endmodule

bind stpc_top stpc_chk i_chk (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr(wr), .rd(rd), .rdata(rdata), .rx_sym(rx_sym), .tx(tx));

// ---- bench/stpc_partner.sv ----
module stpc_partner
  import stpc_pkg::*;
(
  input wire logic clk,
  input stpc_sym_t tx [STPC_NLANE],
  input wire logic bad,
  output logic [7:0] rx_sym [STPC_NLANE]
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] last [STPC_NLANE] = '{default: 8'h5a};
  // far-end echo; idle lines toggle every cycle
  always @(posedge clk)
    last <= rx_sym;
  always_comb
    for (int i = 0; i < STPC_NLANE; i++)
      rx_sym[i] = tx[i].valid ? tx[i].sym ^ {8{bad}} : ~last[i];
endmodule

// ---- bench/tb_top.sv ----
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import stpc_pkg::*;
  logic clk = 0, nrst = 0, wr = 0, rd = 0, bad = 0;
  logic [11:0] addr = 0, a;
  logic [31:0] wdata = 0, rdata, got;
  logic [7:0] rx_sym [STPC_NLANE];
  stpc_sym_t tx [STPC_NLANE];
  int mismatches = 0, checked = 0, n, base;
  logic [3:0] dl [4] = '{STPC_SYM_0, STPC_SYM_1, STPC_SYM_4, STPC_SYM_8};
  logic [31:0] rows [5][3] = '{'{32'h210, 32'h13121110, 32'h13121110},
    '{32'h214, 32'h17161514, 32'h17161514}, '{32'h218, 32'h1b1a1918, 32'h1b1a1918},
    '{32'h21c, 32'h1f1e1d1c, 32'h1f1e1d1c}, '{32'h300, 32'hffff, 32'h0}};
  stpc_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .rx_sym(rx_sym), .tx(tx));
  stpc_partner i_far (.clk(clk), .tx(tx), .bad(bad), .rx_sym(rx_sym));
  initial forever #12.5 clk = ~clk;
  task automatic wreg(input logic [11:0] ad, input logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    wdata <= d;
    wr <= 1'h1;
    @(posedge clk);
    wr <= 1'h0;
  endtask
  task automatic rreg(input logic [11:0] ad, output logic [31:0] d);
    @(posedge clk);
    addr <= ad;
    rd <= 1'h1;
    @(posedge clk);
    rd <= 1'h0;
    @(negedge clk);
    d = rdata;
  endtask
  task automatic cmp(input string s, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", s, e, g);
    end
  endtask
  task automatic finish_test;
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic waitv(input int l, output int c);
    c = 0;
    do
    begin
      @(negedge clk);
      c++;
      if (c > 40)
      begin
        mismatches++;
        finish_test();
      end
    end
    while (tx[l].valid !== 1'h1);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    nrst <= 1'h1;
    rreg(STPC_OFS_EVEN, got);
    cmp("even reset", STPC_CTRL_RST, got);
    rreg(STPC_OFS_ODD, got);
    cmp("odd reset", STPC_CTRL_RST, got);
    foreach (rows[r])
    begin
      wreg(rows[r][0][11:0], rows[r][1]);
      rreg(rows[r][0][11:0], got);
      cmp("readback", rows[r][2], got);
    end
    $display("register test done");
    for (int l = 0; l < 4; l++)
      for (int c = 0; c < 4; c++)
      begin
        a = l < 2 ? STPC_OFS_EVEN : STPC_OFS_ODD;
        wreg(a, (32'h1 << (16 + l % 2)) | (c << (2 * (l % 2))));
        waitv(l, n);
        if (c == 0)
          base = n;
        cmp("delay", 32'(dl[c]), 32'(n - base));
        for (int j = 0; j < 16; j++)
        begin
          cmp("symbol", 32'(8'h10 + j), 32'(tx[l].sym));
          @(negedge clk);
        end
        wreg(a, 32'h0);
        repeat (4) @(negedge clk);
        cmp("idle", 32'h0, 32'(tx[l].valid));
      end
    $display("pattern test done");
    wreg(STPC_OFS_EVEN, 32'h100_0000);
    waitv(0, n);
    repeat (20) @(negedge clk);
    rreg(STPC_OFS_ERR, got);
    cmp("clean err", 32'h0, got);
    bad <= 1'h1;
    repeat (4) @(posedge clk);
    bad <= 1'h0;
    rreg(STPC_OFS_ERR, got);
    cmp("sticky err", 32'h1, got);
    wreg(STPC_OFS_EVEN, 32'h0);
    wreg(STPC_OFS_ERR, 32'hf);
    rreg(STPC_OFS_ERR, got);
    cmp("cleared err", 32'h0, got);
    cmp("prbs off", 32'h0, 32'(tx[0].valid));
    wreg(STPC_OFS_ODD, 32'h200_0000);
    waitv(3, n);
    wreg(STPC_OFS_ODD, 32'h0);
    repeat (4) @(negedge clk);
    cmp("prbs off", 32'h0, 32'(tx[3].valid));
    $display("prbs test done");
    finish_test();
  end
endmodule
